/* rtl/psbp_pkg.sv */
// constants, state type and conversion figures for the phase-shift bridge pwm logic
// assumes analog levels arrive as millivolt codes and resistances as ohm codes
`default_nettype none
package psbp_pkg;
    // ==========================================
    // clock
    localparam int unsigned CLK_PERIOD_NS = 100; // sys_clk at 10 MHz
    // ==========================================
    // oscillator: period = 5*r*c/48 + 120 ns, ramp peaks at 2.35 V
    localparam int unsigned RAMP_PEAK_MV = 2350;
    localparam int unsigned OSC_NUM = 5;
    localparam int unsigned OSC_DEN = 48;
    localparam int unsigned OHM_PF_PER_NS = 1000; // 1 ohm*pF is 1e-3 ns
    localparam int unsigned OSC_OFFSET_NS = 120;
    localparam int unsigned OSC_MIN_CYCLES = 2; // a shorter ramp cannot toggle cleanly
    // ==========================================
    // dead time: 25e-12*r/v + 25 ns, with v in mV this is 25*r/v ns
    localparam int unsigned DEAD_COEF = 25;
    localparam int unsigned DEAD_FIXED_NS = 25;
    localparam int unsigned DEAD_MAX_CYCLES = 255;
    // delay voltage: 0.75*(cs - ads) + 0.5 V, kept between 0.5 V and 2 V
    localparam int unsigned VDEL_GAIN_NUM = 3;
    localparam int unsigned VDEL_GAIN_DEN = 4;
    localparam int unsigned VDEL_FLOOR_MV = 500;
    localparam int unsigned VDEL_CEIL_MV = 2000;
    // ==========================================
    // comparator thresholds
    localparam logic [11:0] NOLOAD_OFF_MV = 12'h1F4; // 500 mV
    localparam logic [11:0] NOLOAD_ON_MV = 12'h258; // 600 mV
    localparam logic [11:0] DISABLE_MV = 12'h1F4; // 500 mV
    localparam logic [11:0] OVERCURRENT_MV = 12'h9C4; // 2.5 V
    localparam int unsigned SOFTSTOP_SINK_RATIO = 10; // sink is ten timing currents
    // ==========================================
    // soft-start / disable sequencer states
    typedef enum logic [2:0] {
        PSBP_LOCKOUT,
        PSBP_REFFAULT,
        PSBP_DISABLED,
        PSBP_SOFTSTOP,
        PSBP_ACTIVE
    } psbp_state_e;
endpackage
`default_nettype wire

/* rtl/psbp_leg_if.sv */
// signals between the phase controller and one bridge leg's dead-time stage
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface psbp_leg_if;
    logic cmd; // wanted state: 1 high side on, 0 low side on
    logic [7:0] deadCycles; // gap length in clocks, at least one
    logic kill; // force both drives low
    logic bypass; // dead time defeated
    logic highDrive; // high-side gate drive
    logic lowDrive; // low-side gate drive
    modport ctrl (output cmd, output deadCycles, output kill, output bypass,
        input highDrive, input lowDrive);
    modport leg (input cmd, input deadCycles, input kill, input bypass,
        output highDrive, output lowDrive);
endinterface
`default_nettype wire

/* rtl/psbp_deadtime.sv */
// dead-time stage for one bridge leg: both drives low for a gap on each swap
// assumes deadCycles is at least one and stable within a gap
`timescale 1ns/1ps
`default_nettype none
module psbp_deadtime
    import psbp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    psbp_leg_if.leg lg
);
    // ==========================================
    // state
    logic seenCmd_q; // last command acted on
    logic [7:0] gap_q; // clocks of gap still to run
    logic high_q; // high drive flop
    logic low_q; // low drive flop
    wire cmdChanged = lg.cmd != seenCmd_q;
    wire gapRunning = gap_q != 8'h00;
    wire [7:0] gapStart = lg.deadCycles - 8'h01;
    wire [7:0] gap_d = (lg.kill || (cmdChanged && !lg.bypass)) ? gapStart :
        (lg.bypass ? 8'h00 : (gapRunning ? gap_q - 8'h01 : 8'h00));
    // drives are on only with no kill and, unless bypassed, no gap pending and no change just seen
    wire quiet = !lg.kill && (lg.bypass || (!cmdChanged && !gapRunning));
    wire high_d = quiet && lg.cmd;
    wire low_d = quiet && !lg.cmd;
    // ==========================================
    // registers; a kill also arms a full gap so restart never overlaps
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            seenCmd_q <= 1'b0;
            gap_q <= 8'h00;
            high_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            seenCmd_q <= lg.cmd; // RL6
            gap_q <= gap_d; // RL6
            high_q <= high_d; // RL2
            low_q <= low_d; // RL2
        end
    end
    assign lg.highDrive = high_q;
    assign lg.lowDrive = low_q;
    // ==========================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // a defeated dead time swaps in one edge, so only gapped swaps are held to this
    AST_NO_OVERLAP: assert property ($rose(high_q) && !$past(lg.bypass)
        |-> $past(!low_q, 1)) // RL6
        else $error("leg drives swapped with no gap");
    AST_BYPASS_SWAP: assert property (lg.bypass && !lg.kill && $past(lg.bypass)
        |=> (high_q == $past(lg.cmd)) && (low_q != $past(lg.cmd))) // RL8
        else $error("defeated dead time still left a gap");
endmodule
`default_nettype wire

/* rtl/psbp_top.sv */
// phase-shifted full-bridge pwm control logic: oscillator, phase shift,
// dead time, no-load skipping and the soft-start / disable sequencer
// assumes analog levels are already converted to millivolt codes and
// the comparator-style inputs are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: ramp sawtooth to 2.35 V, period 5RC/48+120ns
// RL2: leg one pair complementary, half oscillator rate
// RL3: leg two pair behaves like leg one
// RL4: leg two lags leg one by pwm comparison
// RL5: leg two duty may stray while shifting
// RL6: dead time between each leg's complementary swaps
// RL7: dead time is 25p*R/Vdel plus 25 ns
// RL8: delay set tied to reference defeats dead time
// RL9: adaptive delay voltage 0.5 to 2 V
// RL10: adaptive input equal sense keeps 0.5 V floor
// RL11: no-load hysteresis, off below 500, on above 600
// RL12: error level clamped to soft-start pin voltage
// RL13: fast shutdown on disable, reference low, lockout
// RL14: reference low or lockout grounds soft-start pin
// RL15: sense at 2.5 V starts ten-times soft stop
// RL16: any fault forces all four drives low
// RL17: held-low pin sources; low power only in lockout
// RL18: cleared fault enters soft start, sourcing current
// RL19: sync pin drives clock out, external pulse overrides
// RL20: sync pulse discharges and restarts the ramp
// RL21: sync input taken as a thresholded level
// RL22: ramp from oscillator or sensed current by mode
// RL23: grounded adaptive input gives four-to-one dead time
// RL24: comparator results sampled once per clock
module psbp_top
    import psbp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [16:0] timingResistor, // ohms
    input wire logic [9:0] timingCapacitor, // pF
    input wire logic [16:0] leg1DeadtimeSet, // delay resistor, ohms
    input wire logic [16:0] leg2DeadtimeSet, // delay resistor, ohms
    input wire logic leg1DeadtimeAtRef, // delay pin tied to reference
    input wire logic leg2DeadtimeAtRef, // delay pin tied to reference
    input wire logic [11:0] errorAmpOutput, // mV
    input wire logic [11:0] currentSense, // mV
    input wire logic [11:0] adaptiveDelayInput, // mV
    input wire logic [11:0] softstartDisablePin, // mV
    input wire logic peakCurrentMode, // ramp input carries sensed current
    input wire logic refLow, // reference below 4 V
    input wire logic undervoltageLockout, // supply under start threshold
    input wire logic syncIn, // sync pin level after 1.9/2.1 V threshold
    output logic syncOut, // sync pin drive value
    output logic syncOe, // sync pin driven while high
    output logic rampDischarge, // discharge timing and ramp filter caps
    output logic leg1HighDrive,
    output logic leg1LowDrive,
    output logic leg2HighDrive,
    output logic leg2LowDrive,
    output logic [11:0] errorAmpClamp, // error level after soft-start clamp
    output logic ssPullDown, // internal switch grounds soft-start pin
    output logic ssSink, // pin sinks ten timing currents
    output logic ssSource, // pin sources one timing current
    output logic lowPowerMode // low supply-current state
);
    // ==========================================
    // helper: leg dead time in clocks from resistor and delay voltage
    function automatic logic [7:0] dead_cycles(input logic [16:0] rOhm,
        input logic [11:0] vdelMv);
        int unsigned ns;
        int unsigned cyc;
        ns = (DEAD_COEF * 32'(rOhm)) / 32'(vdelMv) + DEAD_FIXED_NS; // RL7
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // least time rounds up
        if (cyc < 1) begin
            cyc = 1;
        end
        if (cyc > DEAD_MAX_CYCLES) begin
            cyc = DEAD_MAX_CYCLES;
        end
        return cyc[7:0];
    endfunction

    // ==========================================
    // registered copies of the analog codes, one sample per clock
    logic [11:0] errMv_q; // raw error level
    logic [11:0] csMv_q; // current sense
    logic [11:0] adsMv_q; // adaptive input
    logic [11:0] ssMv_q; // soft-start pin
    logic undervoltage_lockout_q; // lockout flag
    logic refLow_q; // reference fault flag
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            errMv_q <= 12'h000;
            csMv_q <= 12'h000;
            adsMv_q <= 12'h000;
            ssMv_q <= 12'h000;
            undervoltage_lockout_q <= 1'b1;
            refLow_q <= 1'b0;
        end else begin
            errMv_q <= errorAmpOutput; // RL24
            csMv_q <= currentSense; // RL24
            adsMv_q <= adaptiveDelayInput; // RL24
            ssMv_q <= softstartDisablePin; // RL24
            undervoltage_lockout_q <= undervoltageLockout; // RL24
            refLow_q <= refLow; // RL24
        end
    end

    // ==========================================
    // soft-start clamp of the error level
    // the clamp follows the pin, so duty grows with the soft-start ramp
    wire [11:0] errClamped = (errMv_q > ssMv_q) ? ssMv_q : errMv_q; // RL12

    // fault detectors, raw so the shutdown is not delayed by the sequencer
    wire overcurrentNow = csMv_q >= OVERCURRENT_MV; // RL15
    wire disableNow = ssMv_q < DISABLE_MV; // RL13
    wire hardFaultNow = undervoltage_lockout_q || refLow_q; // RL13

    // ==========================================
    // oscillator period from timing resistor and capacitor
    wire [31:0] oscProd = 32'(OSC_NUM) * 32'(timingResistor) * 32'(timingCapacitor);
    wire [31:0] oscNs = oscProd / (OSC_DEN * OHM_PF_PER_NS) + OSC_OFFSET_NS; // RL1
    wire [31:0] oscCycRaw = oscNs / CLK_PERIOD_NS; // approximate period rounds down
    wire [15:0] oscCycles = (oscCycRaw < OSC_MIN_CYCLES) ? 16'(OSC_MIN_CYCLES) :
        ((oscCycRaw > 32'h0000FFFF) ? 16'hFFFF : oscCycRaw[15:0]);

    logic [15:0] rampCnt_q; // sawtooth position in clocks
    logic [15:0] period_q; // period in force for the current ramp
    logic syncInPrev_q; // last external sync level
    logic syncPulse_q; // own clock pulse on the sync pin
    logic discharge_q; // ramp discharge strobe

    // an external pulse is only seen while this end is not driving
    wire extSync = syncIn && !syncOe; // RL21
    wire extSyncRise = extSync && !syncInPrev_q; // RL19
    wire ownEnd = rampCnt_q >= (period_q - 16'h0001);
    wire periodEnd = ownEnd || extSyncRise; // RL19
    wire [15:0] rampCnt_d = periodEnd ? 16'h0000 : rampCnt_q + 16'h0001; // RL20

    // oscillator process; new period values apply from the next ramp
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rampCnt_q <= 16'h0000;
            period_q <= 16'(OSC_MIN_CYCLES);
            syncInPrev_q <= 1'b0;
            syncPulse_q <= 1'b0;
            discharge_q <= 1'b0;
        end else begin
            rampCnt_q <= rampCnt_d; // RL20
            period_q <= periodEnd ? oscCycles : period_q; // RL1
            syncInPrev_q <= extSync;
            syncPulse_q <= ownEnd && !extSyncRise; // RL19
            discharge_q <= periodEnd; // RL20
        end
    end
    assign syncOut = syncPulse_q; // RL19
    assign syncOe = syncPulse_q; // drive only the pulse, let others pull in between
    assign rampDischarge = discharge_q;

    // ==========================================
    // pwm comparator: ramp source by control mode
    wire [31:0] rampScaled = (32'(rampCnt_q) * RAMP_PEAK_MV) / 32'(period_q); // RL1
    wire [11:0] rampOscMv = rampScaled[11:0];
    wire [11:0] rampMv = peakCurrentMode ? csMv_q : rampOscMv; // RL22
    wire pwmTrip = rampMv >= errClamped; // RL4

    // ==========================================
    // phase logic: leg one toggles each period, leg two copies it on trip
    logic leg1Cmd_q; // leg one wanted state
    logic leg2Cmd_q; // leg two wanted state
    logic tripped_q; // comparator already fired this period
    // an untripped period ends with leg two catching up: full shift, full duty
    wire leg1Cmd_d = periodEnd ? !leg1Cmd_q : leg1Cmd_q; // RL2
    wire leg2Cmd_d = (periodEnd && !tripped_q) ? leg1Cmd_q :
        ((!periodEnd && pwmTrip && !tripped_q) ? leg1Cmd_q : leg2Cmd_q); // RL4
    wire tripped_d = periodEnd ? 1'b0 : (tripped_q || pwmTrip);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            leg1Cmd_q <= 1'b0;
            leg2Cmd_q <= 1'b0;
            tripped_q <= 1'b0;
        end else begin
            leg1Cmd_q <= leg1Cmd_d; // RL2
            leg2Cmd_q <= leg2Cmd_d; // RL5
            tripped_q <= tripped_d;
        end
    end

    // ==========================================
    // no-load comparator with 100 mV hysteresis
    logic noLoad_q; // outputs idled by light load
    wire noLoad_d = (errClamped < NOLOAD_OFF_MV) ? 1'b1 :
        ((errClamped > NOLOAD_ON_MV) ? 1'b0 : noLoad_q); // RL11
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            noLoad_q <= 1'b1;
        end else begin
            noLoad_q <= noLoad_d; // RL11
        end
    end

    // ==========================================
    // soft-start / disable sequencer
    psbp_state_e state_q;
    psbp_state_e state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            PSBP_SOFTSTOP: begin
                // the stop runs out on the pin, not on the fault
                if (undervoltage_lockout_q) begin
                    state_d = PSBP_LOCKOUT;
                end else if (refLow_q) begin
                    state_d = PSBP_REFFAULT;
                end else if (disableNow) begin
                    state_d = PSBP_ACTIVE; // RL18
                end
            end
            default: begin
                if (undervoltage_lockout_q) begin
                    state_d = PSBP_LOCKOUT; // RL13
                end else if (refLow_q) begin
                    state_d = PSBP_REFFAULT; // RL13
                end else if (overcurrentNow && state_q == PSBP_ACTIVE) begin
                    state_d = PSBP_SOFTSTOP; // RL15
                end else if (disableNow && (state_q == PSBP_ACTIVE ||
                    state_q == PSBP_DISABLED)) begin
                    // a held disable keeps the state, so soft start waits for release
                    // and the sequencer does not flap between active and disabled
                    state_d = PSBP_DISABLED; // RL13
                end else begin
                    state_d = PSBP_ACTIVE; // RL18
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= PSBP_LOCKOUT;
        end else begin
            state_q <= state_d;
        end
    end

    // pin current steering, one mode at a time
    logic pullDown_q; // ground switch on
    logic sink_q; // ten-times sink on
    logic source_q; // timing-current source on
    logic lowPower_q; // lockout supply state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pullDown_q <= 1'b1;
            sink_q <= 1'b0;
            source_q <= 1'b0;
            lowPower_q <= 1'b1;
        end else begin
            pullDown_q <= state_d == PSBP_LOCKOUT || state_d == PSBP_REFFAULT; // RL14
            sink_q <= state_d == PSBP_SOFTSTOP; // RL15
            source_q <= state_d == PSBP_DISABLED || state_d == PSBP_ACTIVE; // RL17
            lowPower_q <= state_d == PSBP_LOCKOUT; // RL17
        end
    end
    assign ssPullDown = pullDown_q;
    assign ssSink = sink_q;
    assign ssSource = source_q;
    assign lowPowerMode = lowPower_q;

    logic [11:0] clamp_q; // registered clamp level for observation
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            clamp_q <= 12'h000;
        end else begin
            clamp_q <= errClamped; // RL12
        end
    end
    assign errorAmpClamp = clamp_q;

    // ==========================================
    // adaptive delay voltage, shared by both legs
    wire [11:0] csOverAds = (csMv_q > adsMv_q) ? (csMv_q - adsMv_q) : 12'h000; // RL10
    wire [31:0] vdelRaw = (32'(csOverAds) * VDEL_GAIN_NUM) / VDEL_GAIN_DEN + VDEL_FLOOR_MV; // RL9
    // the ceiling keeps dead time from falling under a quarter of its light-load value
    wire [11:0] vdelMv = (vdelRaw > VDEL_CEIL_MV) ? 12'(VDEL_CEIL_MV) : vdelRaw[11:0]; // RL23

    // kill is raw: outputs drop at the edge after the fault is first sampled
    wire killAll = hardFaultNow || overcurrentNow || disableNow || noLoad_q ||
        state_q != PSBP_ACTIVE; // RL16

    // ==========================================
    // two dead-time stages, one per leg
    psbp_leg_if legs[2] ();
    wire [1:0] legCmd = {leg2Cmd_q, leg1Cmd_q}; // RL3
    wire [16:0] legR[2];
    wire [1:0] legAtRef = {leg2DeadtimeAtRef, leg1DeadtimeAtRef};
    assign legR[0] = leg1DeadtimeSet;
    assign legR[1] = leg2DeadtimeSet;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_leg
            assign legs[g].cmd = legCmd[g];
            assign legs[g].deadCycles = dead_cycles(legR[g], vdelMv); // RL6
            assign legs[g].kill = killAll; // RL16
            assign legs[g].bypass = legAtRef[g]; // RL8
            psbp_deadtime u_dead (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .lg(legs[g])
            );
        end
    endgenerate
    assign leg1HighDrive = legs[0].highDrive;
    assign leg1LowDrive = legs[0].lowDrive;
    assign leg2HighDrive = legs[1].highDrive; // RL3
    assign leg2LowDrive = legs[1].lowDrive;

    // ==========================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_NOLOAD_OFF: assert property (errClamped < NOLOAD_OFF_MV |=> noLoad_q) // RL11
        else $error("no-load idle not entered below 500 mV");
    AST_NOLOAD_HOLD: assert property (noLoad_q && errClamped <= NOLOAD_ON_MV
        |=> noLoad_q) // RL11
        else $error("no-load idle released below 600 mV");
    AST_SOFTSTOP_SINK: assert property (state_q == PSBP_ACTIVE && overcurrentNow &&
        !hardFaultNow |=> ssSink && !ssSource) // RL15
        else $error("overcurrent did not start the soft stop");
    AST_LOCKOUT_PULL: assert property (undervoltage_lockout_q |=> ssPullDown && lowPowerMode) // RL14
        else $error("lockout left soft-start pin ungrounded");
    AST_FAULT_KILL: assert property ((hardFaultNow || overcurrentNow || disableNow)
        |=> !leg1HighDrive && !leg1LowDrive && !leg2HighDrive && !leg2LowDrive) // RL16
        else $error("drive stayed on after a fault");
    AST_SYNC_PULSE: assert property ($rose(syncOut) |=> !syncOut ##1 !syncOut) // RL19
        else $error("sync out pulse longer than one clock");
    AST_EXT_RESTART: assert property (extSyncRise |=> rampCnt_q == 16'h0000 &&
        rampDischarge) // RL20
        else $error("external sync did not restart the ramp");
    AST_CLAMP: assert property (1'b1 |=> errorAmpClamp <= $past(ssMv_q)) // RL12
        else $error("error level above soft-start pin");
    AST_HALF_RATE: assert property (periodEnd |=> leg1Cmd_q != $past(leg1Cmd_q)) // RL2
        else $error("leg one command missed a period toggle");
    // a pin still held low must not let the sequencer drift back to active
    AST_DISABLE_HOLD: assert property (state_q == PSBP_DISABLED && disableNow &&
        !hardFaultNow |=> state_q == PSBP_DISABLED) // RL13
        else $error("disable released while the pin was still low");
endmodule
`default_nettype wire

/* verification/psbp_gate_model.sv */
// gate-drive stand-in for one bridge leg: times the both-off gap
// assumes both drives are registers on sys_clk
`timescale 1ns/1ps
`default_nettype none
module psbp_gate_model (
    input wire logic sys_clk,
    input wire logic hi, // high-side command
    input wire logic lo, // low-side command
    output logic [7:0] gap, // both-off clocks before the last turn-on
    output logic shoot // sticky: both switches were on together
);
    logic [7:0] offCnt; // both-off run length so far
    logic hiQ; // last high command
    logic loQ; // last low command
    initial begin
        gap = 8'h00;
        shoot = 1'b0;
        offCnt = 8'h00;
        hiQ = 1'b0;
        loQ = 1'b0;
    end
    // ==========================================
    // gap timing; a real bridge shorts the rail if both conduct
    always @(posedge sys_clk) begin
        hiQ <= hi;
        loQ <= lo;
        if (hi & lo) begin
            shoot <= 1'b1;
        end
        // saturate so a long idle stays visible, not wrapped
        if (hi | lo) begin
            offCnt <= 8'h00;
        end else if (offCnt != 8'hFF) begin
            offCnt <= offCnt + 8'h01;
        end
        if ((hi & !hiQ) | (lo & !loQ)) begin
            gap <= offCnt;
        end
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the phase-shift bridge pwm logic
// assumes psbp_top and psbp_gate_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, g) begin nChecks++; if ((e) !== (g)) begin errCount++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    typedef struct {int id; logic [11:0] v;} psbp_note_s;
    psbp_note_s q[$]; // expected results, oldest first
    psbp_note_s nt;
    string nm[10] = '{"drives", "pulldown", "source", "sink", "lowpower",
        "clamp", "gap1", "gap2", "shoot", "pulses"};
    logic sys_clk = 1'b0, rstn = 1'b0, atRef1 = 1'b0, atRef2 = 1'b0;
    logic pcm = 1'b0, refLow = 1'b0, undervoltage_lockout = 1'b1, ext = 1'b0;
    logic [16:0] rT = 17'h14050, r1, r2; // 82 kohm timing, delay resistors
    logic [9:0] cT = 10'h0DC; // 220 pF
    logic [11:0] ea = 12'h5DC, cs = 12'h000, adaptive_delay_input = 12'h000, ss = 12'hBB8;
    wire logic sOut, sOe, rDis, h1, l1, h2, l2, pd, snk, src, lp, sh1, sh2;
    wire logic [11:0] clamp;
    wire logic [7:0] g1, g2;
    // sync wire is pulled down, so released means low
    wire logic syncPin = sOe ? sOut : ext;
    int errCount = 0, nChecks = 0, cnt;
    int csA[3] = '{0, 2000, 2000}, adsA[3] = '{0, 0, 2000}, vd[3] = '{20, 80, 20};
    psbp_top i_psbp_top (.sys_clk(sys_clk), .rstn(rstn), .timingResistor(rT),
        .timingCapacitor(cT), .leg1DeadtimeSet(r1), .leg2DeadtimeSet(r2),
        .leg1DeadtimeAtRef(atRef1), .leg2DeadtimeAtRef(atRef2), .errorAmpOutput(ea),
        .currentSense(cs), .adaptiveDelayInput(adaptive_delay_input), .softstartDisablePin(ss),
        .peakCurrentMode(pcm), .refLow(refLow), .undervoltageLockout(undervoltage_lockout),
        .syncIn(syncPin), .syncOut(sOut), .syncOe(sOe), .rampDischarge(rDis),
        .leg1HighDrive(h1), .leg1LowDrive(l1), .leg2HighDrive(h2), .leg2LowDrive(l2),
        .errorAmpClamp(clamp), .ssPullDown(pd), .ssSink(snk), .ssSource(src),
        .lowPowerMode(lp));
    psbp_gate_model gm1 (.sys_clk(sys_clk), .hi(h1), .lo(l1), .gap(g1), .shoot(sh1));
    psbp_gate_model gm2 (.sys_clk(sys_clk), .hi(h2), .lo(l2), .gap(g2), .shoot(sh2));
    // ==========================================
    // clock, 100 ns period
    initial forever #50 sys_clk = ~sys_clk;
    function automatic logic [11:0] pick(input int id);
        case (id)
            0: return {8'h00, h1, l1, h2, l2};
            1: return {11'h000, pd};
            2: return {11'h000, src};
            3: return {11'h000, snk};
            4: return {11'h000, lp};
            5: return clamp;
            6: return {4'h0, g1};
            7: return {4'h0, g2};
            8: return {11'h000, sh1 | sh2};
            default: return 12'(cnt);
        endcase
    endfunction
    task automatic note(input int id, input logic [11:0] v);
        q.push_back('{id, v});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // counts sync pulses (w 0), discharges (w 1) or cycles of equal high drives (w 2)
    task automatic count(input int w, input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1 cnt += (w == 0) ? int'(sOut) : ((w == 1) ? int'(rDis) : int'(h1 == h2));
        end
    endtask
    task automatic wrapUp();
        if (errCount == 0 && nChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // monitor: settled outputs against the oldest notes
    always @(negedge sys_clk) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            `CMP(nm[nt.id], nt.v, pick(nt.id))
        end
    end
    // watchdog, far beyond the ~1600 cycles the run needs
    initial begin
        #(5000 * 100);
        errCount++;
        wrapUp();
    end
    // ==========================================
    // main sequence
    initial begin
        cnt = $urandom(18);
        // multiples of 80 ohm keep the gap figures exact; under 30 kohm a gap
        // stays shorter than the 19-clock spacing of leg command changes
        r1 = 17'(80 * (125 + $urandom % 250));
        r2 = 17'(80 * (125 + $urandom % 250));
        tick(16);
        rstn <= 1'b1;
        note(1, 1);
        note(4, 1);
        note(0, 0);
        undervoltage_lockout <= 1'b0;
        tick(3);
        note(1, 0);
        note(4, 0);
        note(2, 1);
        repeat (4) begin
            ea <= 12'(700 + $urandom % 3000);
            ss <= 12'(600 + $urandom % 3000);
            tick(4);
            note(5, (ea < ss) ? ea : ss);
        end
        ea <= 12'h5DC;
        ss <= 12'hBB8;
        for (int j = 0; j < 3; j++) begin
            cs <= 12'(csA[j]);
            adaptive_delay_input <= 12'(adsA[j]);
            tick(200);
            note(6, 12'((r1 / vd[j] + 124) / 100));
            note(7, 12'((r2 / vd[j] + 124) / 100));
            note(8, 0);
        end
        cs <= 12'h000;
        adaptive_delay_input <= 12'h000;
        count(0, 190);
        note(9, 10);
        for (int k = 0; k < 40 && sOut !== 1'b1; k++) begin
            tick(1);
            #1;
        end
        tick(5);
        ext <= 1'b1;
        count(1, 4);
        note(9, 1);
        tick(1);
        ext <= 1'b0;
        count(0, 12);
        note(9, 0);
        atRef1 <= 1'b1;
        tick(100);
        note(6, 0);
        // peak current mode, no gaps: untripped gives full shift, tripped one clock
        atRef2 <= 1'b1;
        pcm <= 1'b1;
        tick(40);
        count(2, 190);
        note(9, 0);
        cs <= 12'h7D0;
        tick(40);
        count(2, 190);
        note(9, 180);
        atRef1 <= 1'b0;
        atRef2 <= 1'b0;
        pcm <= 1'b0;
        cs <= 12'h000;
        ea <= 12'h190;
        tick(4);
        note(0, 0);
        ea <= 12'h226;
        tick(60);
        note(0, 0);
        ea <= 12'h5DC;
        tick(60);
        cs <= 12'hA28;
        tick(3);
        note(3, 1);
        note(2, 0);
        note(0, 0);
        cs <= 12'h000;
        ss <= 12'h190;
        tick(4);
        note(3, 0);
        note(2, 1);
        note(0, 0);
        ss <= 12'hBB8;
        tick(3);
        refLow <= 1'b1;
        tick(3);
        note(1, 1);
        note(4, 0);
        note(0, 0);
        tick(2);
        wrapUp();
    end
endmodule
`default_nettype wire
